// ### ccdst_sample_output.sv
// sample-pulse routing, conversion latency and output bus of the digitiser
//
// Functional notes
// - video pulse high connects video capacitors
// - reset pulse high connects reset capacitors while double sampling
// - data appears seven clocks after sample fall
// - one-channel double sampling cannot space evenly
// - colour mode converts three inputs per pixel
// - monochrome powers down unused channels
// - pin or bit disables output drivers
// - clamp source zero clamps during reset pulse
`timescale 1ns/100ps
`default_nettype none

module ccdst_sample_output (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // sample pulses from the controller and the disable pin, all asynchronous pins
    input wire logic video_sample_pulse_i,
    input wire logic reset_sample_pulse_i,
    input wire logic output_disable_pin_i,
    // configuration
    input wire logic double_sample_mode_i,
    input wire ccdst_pkg::ccdst_mode_e chan_mode_i,
    input wire logic [1:0] mono_select_i,
    input wire logic [1:0] clamp_source_select_i,
    input wire logic output_disable_bit_i,
    // converter core results, same clock domain
    input wire ccdst_pkg::ccdst_pixel_s pixel_i,
    // receiver handshake
    input wire logic out_ready_i,
    output logic out_valid_o,
    output logic [1:0] out_chan_o,
    // output bus, three-state pin form
    output logic [9:0] conversion_output_bus_o,
    output logic conversion_output_bus_oe_o,
    // analogue switch controls and status
    output logic video_cap_connect_o,
    output logic reset_cap_connect_o,
    output logic clamp_close_o,
    output logic [2:0] channel_power_o,
    output logic spacing_unavail_o,
    output logic overrun_o
);
    import ccdst_pkg::*;

    // words per pixel for a mode
    function automatic logic [1:0] words_per_pixel(input ccdst_mode_e m);
        case (m)
            CCDST_THREE: words_per_pixel = 2'h3;
            CCDST_TWO: words_per_pixel = 2'h2;
            default: words_per_pixel = 2'h1;
        endcase
    endfunction

    // synchroniser chains: bit0 video, bit1 reset, bit2 disable pin
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic vid_prev; // third stage, only for edge detect
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            // two flops before any logic looks at the pin
            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= (gi == 0) ? video_sample_pulse_i :
                                 (gi == 1) ? reset_sample_pulse_i : output_disable_pin_i;
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    // edge detect on the settled video pulse
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            vid_prev <= 1'b0;
        end else begin
            vid_prev <= sync2[0];
        end
    end

    wire vid_s = sync2[0];
    wire rst_s = sync2[1];
    wire oeb_s = sync2[2];
    wire fall_det = vid_prev & ~vid_s;

    // capacitor routing follows the pulses
    assign video_cap_connect_o = vid_s;
    // reset capacitors only used while double sampling
    assign reset_cap_connect_o = rst_s & double_sample_mode_i;
    // without double sampling the reset pulse serves only the clamp
    assign clamp_close_o = rst_s & (clamp_source_select_i == CLAMP_SRC_RESET_SAMPLE_PULSE);
    // a single clock per pixel leaves no room for even spacing
    assign spacing_unavail_o = double_sample_mode_i & (chan_mode_i == CCDST_ONE);

    // channel power: blue off in two-channel, all but one off in mono
    wire [2:0] mono_onehot = 3'h1 << mono_select_i;
    assign channel_power_o = (chan_mode_i == CCDST_THREE) ? 3'h7 :
                             (chan_mode_i == CCDST_TWO) ? 3'h3 : mono_onehot;

    // latency pipeline: event bit and captured pixel ride together
    logic [PIPE_DEPTH-1:0] pipe_vld;
    ccdst_pixel_s pipe_pix [PIPE_DEPTH];

    // shift one stage per clock; no stall, latency is fixed
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pipe_vld <= '0;
        end else begin
            pipe_vld <= {pipe_vld[PIPE_DEPTH-2:0], fall_det};
        end
    end

    // pixel data needs no reset, its valid bit guards it
    always_ff @(posedge clk_i) begin
        pipe_pix[0] <= pixel_i;
        for (int i = 1; i < PIPE_DEPTH; i++) begin
            pipe_pix[i] <= pipe_pix[i-1];
        end
    end

    wire pix_arrive = pipe_vld[PIPE_DEPTH-1];
    ccdst_pixel_s arr_pix;
    assign arr_pix = pipe_pix[PIPE_DEPTH-1];

    // word sequencer: one word per clock into the buffer
    typedef enum logic {SEQ_IDLE, SEQ_EMIT} ccdst_seq_e;
    ccdst_seq_e state;
    ccdst_seq_e next_state;
    ccdst_pixel_s cur_pix;
    logic [1:0] idx;          // next word index within the pixel
    logic [1:0] total;        // words in this pixel
    logic buf_in_ready;

    // first word goes straight from the pipe so latency holds
    wire start = pix_arrive & (state == SEQ_IDLE);
    wire [1:0] emit_idx = start ? 2'h0 : idx;
    wire [1:0] emit_total = start ? words_per_pixel(chan_mode_i) : total;
    ccdst_pixel_s emit_pix;
    assign emit_pix = start ? arr_pix : cur_pix;
    wire emit_valid = start | (state == SEQ_EMIT);
    // mono mode reports the chosen input, colour walks red green blue
    wire [1:0] emit_chan = (emit_total == 2'h1) ? mono_select_i : emit_idx;
    wire [WORD_W-1:0] emit_data = (emit_chan == CHAN_RED) ? emit_pix.red :
                                  (emit_chan == CHAN_GREEN) ? emit_pix.green : emit_pix.blue;
    wire push = emit_valid & buf_in_ready;
    wire last_word = (emit_idx + 2'h1) == emit_total;
    // a pixel that arrives mid-sequence cannot be held; flag it
    assign overrun_o = pix_arrive & (state == SEQ_EMIT);

    // next-state selection
    always_comb begin
        next_state = state;
        if (push & last_word) begin
            next_state = SEQ_IDLE;
        end else if (emit_valid) begin
            next_state = SEQ_EMIT;
        end
    end

    // sequencer registers; receiver stall freezes the index
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= SEQ_IDLE;
            idx <= 2'h0;
            total <= 2'h0;
            cur_pix <= '0;
        end else begin
            state <= next_state;
            if (start) begin
                cur_pix <= arr_pix;
                total <= emit_total;
            end
            if (push) begin
                idx <= emit_idx + 2'h1;
            end else if (start) begin
                idx <= 2'h0;
            end
        end
    end

    // two-entry output buffer, head entry drives the bus
    ccdst_word_s buf_q [BUF_DEPTH];
    logic [1:0] buf_cnt;
    ccdst_word_s in_word;
    assign in_word = '{chan: emit_chan, data: emit_data};
    wire pop = out_valid_o & out_ready_i;
    assign out_valid_o = buf_cnt != 2'h0;
    assign buf_in_ready = (buf_cnt != 2'h2) | pop;
    assign conversion_output_bus_o = buf_q[0].data;
    assign out_chan_o = buf_q[0].chan;

    // occupancy count
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            buf_cnt <= 2'h0;
        end else begin
            buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
        end
    end

    // entry moves: pop shifts, push fills the first free slot
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end else begin
            if (pop) begin
                buf_q[0] <= (push & (buf_cnt == 2'h1)) ? in_word : buf_q[1];
                if (push & (buf_cnt == 2'h2)) begin
                    buf_q[1] <= in_word;
                end
            end else if (push) begin
                if (buf_cnt == 2'h0) begin
                    buf_q[0] <= in_word;
                end else begin
                    buf_q[1] <= in_word;
                end
            end
        end
    end

    // either disable source floats the bus
    assign conversion_output_bus_oe_o = ~(oeb_s | output_disable_bit_i);
    // checks
    property p_video_cap;
        @(posedge clk_i) disable iff (srst_i)
        video_cap_connect_o |-> $past(video_sample_pulse_i, 2);
    endproperty
    a_video_cap: assert property (p_video_cap) else $error("video switch without pulse");

    property p_reset_cap;
        @(posedge clk_i) disable iff (srst_i)
        reset_cap_connect_o |-> double_sample_mode_i && $past(reset_sample_pulse_i, 2);
    endproperty
    a_reset_cap: assert property (p_reset_cap) else $error("reset switch misrouted");

    property p_latency;
        @(posedge clk_i) disable iff (srst_i)
        $fell(vid_s) && !$past(srst_i) |-> ##5 pix_arrive;
    endproperty
    a_latency: assert property (p_latency) else $error("pixel not at output stage");

    property p_first_word;
        @(posedge clk_i) disable iff (srst_i)
        (pix_arrive && state == SEQ_IDLE && buf_cnt == 2'h0) |=> out_valid_o;
    endproperty
    a_first_word: assert property (p_first_word) else $error("word late on bus");

    property p_three_words;
        @(posedge clk_i) disable iff (srst_i)
        (start && chan_mode_i == CCDST_THREE) |=> state == SEQ_EMIT && total == 2'h3;
    endproperty
    a_three_words: assert property (p_three_words) else $error("colour pixel not walked");

    property p_mono_power;
        @(posedge clk_i) disable iff (srst_i)
        chan_mode_i == CCDST_ONE |-> $onehot(channel_power_o);
    endproperty
    a_mono_power: assert property (p_mono_power) else $error("unused channel powered");

    property p_out_disable;
        @(posedge clk_i) disable iff (srst_i)
        (($past(output_disable_pin_i, 2) && !$past(srst_i) && !$past(srst_i, 2))
            || output_disable_bit_i) |-> !conversion_output_bus_oe_o;
    endproperty
    a_out_disable: assert property (p_out_disable) else $error("bus driven while disabled");

    property p_clamp;
        @(posedge clk_i) disable iff (srst_i)
        (clamp_source_select_i == CLAMP_SRC_RESET_SAMPLE_PULSE && $past(reset_sample_pulse_i, 2)
            && !$past(srst_i) && !$past(srst_i, 2)) |-> clamp_close_o;
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp open during reset pulse");

    property p_spacing;
        @(posedge clk_i) disable iff (srst_i)
        spacing_unavail_o |-> chan_mode_i == CCDST_ONE;
    endproperty
    a_spacing: assert property (p_spacing) else $error("spacing flag wrong mode");

endmodule

`default_nettype wire

// ### ccdst_pkg.sv
// shared constants and types for the sample-timing and output block
package ccdst_pkg;

    // master clock rate and conversion timing
    localparam int MCLK_PERIOD_NS = 100;       // clk_i period in ns
    localparam int LATENCY_CYC = 7;            // clocks from first edge after sample fall
    localparam int SYNC_STAGES = 2;            // pin synchroniser depth
    localparam int PIPE_DEPTH = LATENCY_CYC - SYNC_STAGES;
    localparam int WORD_W = 10;                // converter word width
    localparam int CHAN_N = 3;                 // processing channels
    localparam int BUF_DEPTH = 2;              // output buffer entries

    // least controller timing, kept for reference by the checker side
    localparam real PIXEL3_MIN_NS = 50.0;
    localparam real PIXEL2_MIN_NS = 33.3;
    localparam real PIXEL1_MIN_NS = 22.2;
    localparam real MCLK23_MIN_NS = 16.6;
    localparam real MCLK1_MIN_NS = 22.2;

    // channel-count modes
    typedef enum logic [1:0] {
        CCDST_THREE,
        CCDST_TWO,
        CCDST_ONE
    } ccdst_mode_e;

    // fixed codes
    localparam logic [1:0] CLAMP_SRC_RESET_SAMPLE_PULSE = 2'h0;    // clamp follows reset pulse
    localparam logic [1:0] CHAN_RED = 2'h0;
    localparam logic [1:0] CHAN_GREEN = 2'h1;
    localparam logic [1:0] CHAN_BLUE = 2'h2;

    // one sampled pixel, all three channels
    typedef struct packed {
        logic [WORD_W-1:0] blue;
        logic [WORD_W-1:0] green;
        logic [WORD_W-1:0] red;
    } ccdst_pixel_s;

    // one converted word with its channel tag
    typedef struct packed {
        logic [1:0] chan;
        logic [WORD_W-1:0] data;
    } ccdst_word_s;

endpackage

// ### ccdst_ctl_model.sv
// scanner controller model: sample pulses paced by the master clock
`timescale 1ns/100ps
`default_nettype none

module ccdst_ctl_model (
    // clock
    input wire logic clk_i,
    // one pixel per high cycle
    input wire logic go_i,
    // sample pulse pins
    output logic video_sample_pulse_o,
    output logic reset_sample_pulse_o
);
    logic was_high = 1'b0; // video pulse seen high at last rise
    logic start = 1'b0; // request latched at the rise
    initial begin
        video_sample_pulse_o = 1'b0;
        reset_sample_pulse_o = 1'b0;
    end
    // video pulse lasts one clock and drops just after a rise
    always @(posedge clk_i) begin
        was_high = video_sample_pulse_o;
        start = go_i;
        #1;
        video_sample_pulse_o = start;
        reset_sample_pulse_o = 1'b0;
    end
    // reset pulse only after the first fall that follows the drop
    always @(negedge clk_i) begin
        if (was_high && !video_sample_pulse_o) begin
            #1;
            reset_sample_pulse_o = 1'b1;
        end
    end
endmodule

`default_nettype wire

// ### ccdst_sample_output_bench.sv
// self-checking bench for the sample timing and output block
`timescale 1ns/100ps
`default_nettype none

module ccdst_sample_output_bench;
    import ccdst_pkg::*;
    // 10 MHz clock, far slower than every pixel and clock minimum
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic go = 1'b0, vsp, rsp, odp = 1'b0, dsm = 1'b0, odb = 1'b0, rdy = 1'b1;
    ccdst_mode_e mode = CCDST_THREE;
    logic [1:0] mono = 2'h0, csel = 2'h0, chan;
    ccdst_pixel_s pixel = '0;
    logic valid, oe, vcap, rcap, clamp, spc, ovr;
    logic [9:0] bus;
    logic [2:0] pwr;
    int err_total = 0, checked = 0, ncv, ncr, ncl, nov, m, s, k;
    int seed = 32'h0000_6834;
    ccdst_word_s expq[$]; // words still owed by the design
    always #50 clk_i = ~clk_i;

    ccdst_ctl_model ctl (.clk_i(clk_i), .go_i(go), .video_sample_pulse_o(vsp),
        .reset_sample_pulse_o(rsp));
    ccdst_sample_output dut (.clk_i(clk_i), .srst_i(srst_i), .video_sample_pulse_i(vsp),
        .reset_sample_pulse_i(rsp), .output_disable_pin_i(odp), .double_sample_mode_i(dsm),
        .chan_mode_i(mode), .mono_select_i(mono), .clamp_source_select_i(csel),
        .output_disable_bit_i(odb), .pixel_i(pixel), .out_ready_i(rdy), .out_valid_o(valid),
        .out_chan_o(chan), .conversion_output_bus_o(bus), .conversion_output_bus_oe_o(oe),
        .video_cap_connect_o(vcap), .reset_cap_connect_o(rcap), .clamp_close_o(clamp),
        .channel_power_o(pwr), .spacing_unavail_o(spc), .overrun_o(ovr));

    // expected word of one channel
    function automatic ccdst_word_s word_of(ccdst_pixel_s p, logic [1:0] ch);
        return {ch, p[ch*10 +: 10]};
    endfunction
    // expected power mask: red, green, blue bits
    function automatic logic [2:0] pwr_of(ccdst_mode_e md, logic [1:0] sel);
        if (md == CCDST_THREE) return 3'h7;
        if (md == CCDST_TWO) return 3'h3;
        return 3'h1 << sel;
    endfunction

    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        checked++;
        if (e !== g) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    // one pixel with random data; lat also times the first word
    task automatic pix(input bit lat);
        logic [31:0] r;
        int i;
        r = $random(seed);
        pixel = r[29:0];
        ncv = 0;
        ncr = 0;
        ncl = 0;
        for (i = 0; i < 3 - int'(mode); i++)
            expq.push_back(word_of(pixel, mode == CCDST_ONE ? mono : i[1:0]));
        go = 1'b1;
        tick();
        go = 1'b0;
        if (lat) begin
            @(posedge clk_i);
            @(posedge clk_i);
            repeat (6) @(posedge clk_i);
            #1 chk("early valid", 0, valid);
            tick();
            chk("latency valid", 1, valid);
        end
        // drain with random receiver stalls; two-entry buffer must lose nothing
        for (i = 0; i < 200 && expq.size() > 0; i++) begin
            r = $random(seed);
            rdy = r[0];
            tick();
        end
        rdy = 1'b1;
        if (expq.size() > 0) begin
            chk("drain timeout", 0, 1);
            finish_test();
        end
        repeat (4) tick();
        chk("video caps", 1, ncv);
        chk("reset caps", dsm, ncr);
        chk("clamp", csel == CLAMP_SRC_RESET_SAMPLE_PULSE, ncl);
    endtask

    // pop model and switch counters, sampled mid-cycle
    always @(negedge clk_i) begin
        if (!srst_i) begin
            ncv = ncv + int'(vcap);
            ncr = ncr + int'(rcap);
            ncl = ncl + int'(clamp);
            nov = nov + int'(ovr);
            if (valid === 1'b1 && rdy) begin
                if (expq.size() == 0) chk("extra word", 0, 1);
                else chk("word", expq.pop_front(), {chan, bus});
            end
        end
    end

    initial begin
        #(100 * 20000);
        chk("watchdog", 0, 1);
        finish_test();
    end

    initial begin
        repeat (5) tick();
        srst_i = 1'b0;
        chk("valid rst", 0, valid);
        chk("oe rst", 1, oe);
        // every mode and channel, clamp codes and double sampling varied
        for (m = 0; m < 3; m++) begin
            for (s = 0; s < 3; s++) begin
                mode = ccdst_mode_e'(m);
                mono = s[1:0];
                dsm = s[0];
                csel = s[1:0];
                pix(s == 0);
                chk("power", pwr_of(mode, mono), pwr);
                chk("spacing", mode == CCDST_ONE && dsm, spc);
            end
        end
        $display("test modes done");
        // full stall: three words against a two-entry buffer
        mode = CCDST_THREE;
        nov = 0;
        rdy = 1'b0;
        go = 1'b1;
        expq.push_back(word_of(pixel, CHAN_RED));
        expq.push_back(word_of(pixel, CHAN_GREEN));
        expq.push_back(word_of(pixel, CHAN_BLUE));
        tick();
        go = 1'b0;
        repeat (15) tick();
        chk("stall valid", 1, valid);
        chk("stall overrun", 0, nov);
        for (k = 0; k < 20 && expq.size() > 0; k++) begin
            rdy = 1'b1;
            tick();
        end
        chk("stall left", 0, expq.size());
        if (expq.size() > 0) finish_test();
        // refused: a second pixel two clocks into a colour walk is dropped
        nov = 0;
        expq.push_back(word_of(pixel, CHAN_RED));
        expq.push_back(word_of(pixel, CHAN_GREEN));
        expq.push_back(word_of(pixel, CHAN_BLUE));
        go = 1'b1;
        tick();
        go = 1'b0;
        tick();
        go = 1'b1;
        tick();
        go = 1'b0;
        repeat (20) tick();
        chk("overrun", 1, nov);
        chk("overrun left", 0, expq.size());
        $display("test stall done");
        // output drivers off by pin, then by bit
        odp = 1'b1;
        repeat (3) tick();
        chk("oe pin", 0, oe);
        odp = 1'b0;
        odb = 1'b1;
        tick();
        chk("oe bit", 0, oe);
        odb = 1'b0;
        repeat (3) tick();
        chk("oe back", 1, oe);
        // reset again mid-run, then one more pixel
        srst_i = 1'b1;
        repeat (2) tick();
        srst_i = 1'b0;
        chk("valid rst2", 0, valid);
        pix(1'b1);
        $display("test output done");
        finish_test();
    end
endmodule

`default_nettype wire
